// >>> logic/drt_timer.sv
/*
 * Dual reload down timer top: register port, pin synchronisers, event
 * noise rejector, two channels, flags, toggle divider and serial clock.
 * Assumes single-cycle register strobes and asynchronous oscillator and event pins.
 */
`timescale 1ns/1ps
// Contract
// RULE_01: two timers, 8-bit counter and reload
// RULE_02: writing one to strobe loads counter
// RULE_03: run bit gates count, value kept
// RULE_04: low nibble read latches high nibble
// RULE_05: underflow reloads, flags, toggles, clocks serial
// RULE_06: mode zero means timer mode, timer1 always
// RULE_07: mode one counts event pin edges
// RULE_08: event mode ignores prescaler settings
// RULE_09: polarity zero falling, one rising edge
// RULE_10: noise filter accepts at second reference fall
// RULE_11: source holds levels 0.98 ms minimum
// RULE_12: source select low or high oscillator
// RULE_13: ratio codes divide 1,4,32,256
// RULE_14: prescaler divides only while running
// RULE_15: software waits 5 ms for oscillator
// RULE_16: underflow sets flag, mask gates request
// RULE_17: toggle output divides underflows by two
// RULE_18: channel select picks timer 0 or 1
// RULE_19: enable shows toggle, else pin high
// RULE_20: software keeps port data one, driven
// RULE_21: enable gating unsynchronised, short pulse possible
// RULE_22: timer1 halved underflow clocks serial interface
// RULE_23: software computes serial reload value
// RULE_24: serial clock at most 1 MHz
// RULE_25: underflow on decrement below zero, reloads
// RULE_26: reset clears toggle, run, mode, selects
module drt_timer
    import drt_pkg::*;
(
    input  wire logic                       MCLK,
    input  wire logic                       RST,
    input  wire logic [drt_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [drt_pkg::DATA_W-1:0] WDATA,
    input  wire logic                       WR,
    input  wire logic                       RD,
    output logic      [drt_pkg::DATA_W-1:0] RDATA,
    input  wire logic                       LOW_SPEED_OSCILLATOR,
    input  wire logic                       HIGH_SPEED_OSCILLATOR,
    input  wire logic                       EVENT_INPUT_PIN,
    output logic                            TOGGLE_PORT_PIN,
    output logic                            SERIAL_CLK,
    output logic                            IRQ_T0,
    output logic                            IRQ_T1
);
    import drt_pkg::*;

    logic [2:0]       pins;
    logic [2:0]       sync_a;
    logic [2:0]       sync_b;
    logic [2:0]       sync_c;
    logic             low_speed_oscillator_tick;
    logic             high_speed_oscillator_tick;
    logic             ev_sync;
    logic [NR_DIV_W-1:0] nr_div;
    logic [NR_DIV_W-1:0] next_nr_div;
    drt_flt_e         flt_state;
    drt_flt_e         next_flt;
    logic             ev_accept;
    logic             next_accept;
    logic             ev_prev;
    logic             nr_fall;
    logic             ext_tick;
    logic             event_mode_select;
    logic             noise_reject_enable;
    logic             event_edge_polarity;
    logic             toggle_channel_select;
    logic             toggle_output_enable;
    logic             source_select_t0;
    logic             source_select_t1;
    logic [1:0]       prescale_ratio_t0;
    logic [1:0]       prescale_ratio_t1;
    logic             run_bit_t0;
    logic             run_bit_t1;
    logic [CNT_W-1:0] reload_value_t0;
    logic [CNT_W-1:0] reload_value_t1;
    logic             underflow_flag_t0;
    logic             underflow_flag_t1;
    logic             underflow_mask_t0;
    logic             underflow_mask_t1;
    logic [12:0]      ctl_q;
    logic [12:0]      next_ctl;
    logic [CNT_W-1:0] next_rld0;
    logic [CNT_W-1:0] next_rld1;
    logic [1:0]       next_flag;
    logic [1:0]       next_mask;
    logic             reload_strobe_t0;
    logic             reload_strobe_t1;
    logic [1:0]       ch_src_tick;
    logic [1:0]       ch_use_ext;
    logic [1:0]       ch_run;
    logic [1:0]       ch_load;
    logic [1:0]       ch_ratio [2];
    logic [CNT_W-1:0] ch_reload [2];
    logic [CNT_W-1:0] ch_count [2];
    logic [1:0]       uf;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] hold0;
    logic [DATA_W-1:0] hold1;
    logic [DATA_W-1:0] next_hold0;
    logic [DATA_W-1:0] next_hold1;
    logic             toggle_output;
    logic             next_toggle;
    logic             serial_div;
    logic             next_serial_div;
    logic             sel_uf;

    // two-stage synchronisers for the oscillators and the event pin
    assign pins = {EVENT_INPUT_PIN, HIGH_SPEED_OSCILLATOR, LOW_SPEED_OSCILLATOR};
    for (genvar gi = 0; gi < 3; gi++) begin : g_sync
        always_ff @(posedge MCLK) begin
            if (RST) begin
                sync_a[gi] <= 1'b0;
                sync_b[gi] <= 1'b0;
                sync_c[gi] <= 1'b0;
            end else begin
                sync_a[gi] <= pins[gi];
                sync_b[gi] <= sync_a[gi];
                sync_c[gi] <= sync_b[gi];
            end
        end
    end

    // rising-edge pulses of the oscillators
    assign low_speed_oscillator_tick = sync_b[0] & ~sync_c[0];
    assign high_speed_oscillator_tick = sync_b[1] & ~sync_c[1];
    assign ev_sync   = sync_b[2];

    // reference divider and noise rejector next values
    always_comb begin
        next_nr_div = nr_div;
        nr_fall     = low_speed_oscillator_tick && (nr_div == NR_DIV_TOP);  // reference falls at wrap
        if (low_speed_oscillator_tick) begin
            next_nr_div = nr_div + NR_ONE;
        end
        next_flt    = flt_state;
        next_accept = ev_accept;
        if (!noise_reject_enable) begin
            next_accept = ev_sync;
            next_flt    = FLT_WAIT;
        end else if (ev_sync == ev_accept) begin
            next_flt = FLT_WAIT;                            // glitch gone, start over
        end else if (nr_fall) begin
            case (flt_state)
                FLT_WAIT: begin
                    next_flt = FLT_HALF;
                end
                FLT_HALF: begin
                    next_accept = ev_sync;                  // [RULE_10]
                    next_flt    = FLT_WAIT;
                end
                default: begin
                    next_flt = FLT_WAIT;
                end
            endcase
        end
    end

    // register the rejector state
    always_ff @(posedge MCLK) begin
        if (RST) begin
            nr_div    <= NR_ZERO;
            flt_state <= FLT_WAIT;
            ev_accept <= 1'b0;
            ev_prev   <= 1'b0;
        end else begin
            nr_div    <= next_nr_div;
            flt_state <= next_flt;
            ev_accept <= next_accept;
            ev_prev   <= ev_accept;
        end
    end

    // counted edge of the accepted event level
    assign ext_tick = event_edge_polarity ? (ev_accept & ~ev_prev)    // [RULE_09]
                                          : (~ev_accept & ev_prev);

    // load strobes are write-only actions, never stored
    assign reload_strobe_t0 = WR && (ADDR == REG_T0CTL) && WDATA[TC_LOAD_BIT];
    assign reload_strobe_t1 = WR && (ADDR == REG_T1CTL) && WDATA[TC_LOAD_BIT];

    assign {event_mode_select, noise_reject_enable, event_edge_polarity,
            toggle_channel_select, toggle_output_enable, source_select_t1, source_select_t0,
            prescale_ratio_t0, run_bit_t0, prescale_ratio_t1, run_bit_t1} = ctl_q;

    // register file writes and flag updates
    always_comb begin
        next_ctl  = ctl_q;
        next_rld0 = reload_value_t0;
        next_rld1 = reload_value_t1;
        next_mask = {underflow_mask_t1, underflow_mask_t0};
        next_flag = {underflow_flag_t1, underflow_flag_t0};
        if (WR) begin
            case (ADDR)
                REG_EVCTL:   next_ctl[12:10] = {WDATA[EV_MODE_BIT], WDATA[EV_NR_BIT], WDATA[EV_POL_BIT]};
                REG_OUTCTL:  next_ctl[9:6] = {WDATA[OUT_TOGGLE_CHANNEL_SELECT_BIT], WDATA[OUT_EN_BIT],
                                              WDATA[OUT_SRC1_BIT], WDATA[OUT_SRC0_BIT]};
                REG_T0CTL:   next_ctl[5:3] = {WDATA[TC_PS_MSB:TC_PS_LSB], WDATA[TC_RUN_BIT]};
                REG_T1CTL:   next_ctl[2:0] = {WDATA[TC_PS_MSB:TC_PS_LSB], WDATA[TC_RUN_BIT]};
                REG_RLD0_LO: next_rld0[3:0] = WDATA;
                REG_RLD0_HI: next_rld0[7:4] = WDATA;
                REG_RLD1_LO: next_rld1[3:0] = WDATA;
                REG_RLD1_HI: next_rld1[7:4] = WDATA;
                REG_MASK:    next_mask = WDATA[1:0];
                REG_FLAG:    next_flag = next_flag & ~WDATA[1:0];   // write one clears
                default:     next_ctl = ctl_q;
            endcase
        end
        next_flag = next_flag | uf;                         // [RULE_16] set wins over clear
    end

    // register the control state
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ctl_q             <= '0;                        // [RULE_26] [RULE_06]
            reload_value_t0   <= CNT_ZERO;
            reload_value_t1   <= CNT_ZERO;
            {underflow_mask_t1, underflow_mask_t0} <= 2'h0;
            {underflow_flag_t1, underflow_flag_t0} <= 2'h0;
        end else begin
            ctl_q             <= next_ctl;
            reload_value_t0   <= next_rld0;
            reload_value_t1   <= next_rld1;
            {underflow_mask_t1, underflow_mask_t0} <= next_mask;
            {underflow_flag_t1, underflow_flag_t0} <= next_flag;
        end
    end

    // per-channel hookup; timer 1 never takes the event input
    assign ch_src_tick[0] = source_select_t0 ? high_speed_oscillator_tick : low_speed_oscillator_tick;  // [RULE_12]
    assign ch_src_tick[1] = source_select_t1 ? high_speed_oscillator_tick : low_speed_oscillator_tick;
    assign ch_use_ext     = {1'b0, event_mode_select};                // [RULE_06] [RULE_07]
    assign ch_run         = {run_bit_t1, run_bit_t0};
    assign ch_load        = {reload_strobe_t1, reload_strobe_t0};
    assign ch_ratio[0]    = prescale_ratio_t0;
    assign ch_ratio[1]    = prescale_ratio_t1;
    assign ch_reload[0]   = reload_value_t0;
    assign ch_reload[1]   = reload_value_t1;

    for (genvar ci = 0; ci < 2; ci++) begin : g_ch
        drt_channel #(
            .W (CNT_W)
        ) u_ch (
            .clk       (MCLK),
            .rst       (RST),
            .src_tick  (ch_src_tick[ci]),
            .ext_tick  (ext_tick),
            .use_ext   (ch_use_ext[ci]),
            .run       (ch_run[ci]),
            .ratio     (ch_ratio[ci]),
            .load      (ch_load[ci]),
            .reload    (ch_reload[ci]),
            .count     (ch_count[ci]),
            .underflow (uf[ci])
        );
    end

    // read data and high-nibble hold buffers
    always_comb begin
        next_rdata = DATA_ZERO;
        next_hold0 = hold0;
        next_hold1 = hold1;
        if (RD) begin
            case (ADDR)
                REG_EVCTL:   next_rdata = {1'b0, event_mode_select, noise_reject_enable, event_edge_polarity};
                REG_OUTCTL:  next_rdata = {toggle_channel_select, toggle_output_enable,
                                           source_select_t1, source_select_t0};
                REG_T0CTL:   next_rdata = {prescale_ratio_t0, 1'b0, run_bit_t0};
                REG_T1CTL:   next_rdata = {prescale_ratio_t1, 1'b0, run_bit_t1};
                REG_RLD0_LO: next_rdata = reload_value_t0[3:0];
                REG_RLD0_HI: next_rdata = reload_value_t0[7:4];
                REG_RLD1_LO: next_rdata = reload_value_t1[3:0];
                REG_RLD1_HI: next_rdata = reload_value_t1[7:4];
                REG_CNT0_LO: begin
                    next_rdata = ch_count[0][3:0];
                    next_hold0 = ch_count[0][7:4];          // [RULE_04]
                end
                REG_CNT0_HI: next_rdata = hold0;
                REG_CNT1_LO: begin
                    next_rdata = ch_count[1][3:0];
                    next_hold1 = ch_count[1][7:4];          // [RULE_04]
                end
                REG_CNT1_HI: next_rdata = hold1;
                REG_FLAG:    next_rdata = {2'h0, underflow_flag_t1, underflow_flag_t0};
                REG_MASK:    next_rdata = {2'h0, underflow_mask_t1, underflow_mask_t0};
                default:     next_rdata = DATA_ZERO;
            endcase
        end
    end

    // register read data
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= DATA_ZERO;
            hold0 <= DATA_ZERO;
            hold1 <= DATA_ZERO;
        end else begin
            RDATA <= next_rdata;
            hold0 <= next_hold0;
            hold1 <= next_hold1;
        end
    end

    // toggle divider, serial clock divider and pin outputs
    always_comb begin
        sel_uf          = toggle_channel_select ? uf[1] : uf[0];        // [RULE_18]
        next_toggle     = toggle_output ^ sel_uf;                       // [RULE_17]
        next_serial_div = serial_div ^ uf[1];                           // [RULE_22]
    end

    // register outputs; enable gating is not aligned to the toggle phase
    always_ff @(posedge MCLK) begin
        if (RST) begin
            toggle_output   <= 1'b0;
            serial_div      <= 1'b0;
            TOGGLE_PORT_PIN <= 1'b1;
            SERIAL_CLK      <= 1'b0;
            IRQ_T0          <= 1'b0;
            IRQ_T1          <= 1'b0;
        end else begin
            toggle_output   <= next_toggle;
            serial_div      <= next_serial_div;
            TOGGLE_PORT_PIN <= toggle_output_enable ? toggle_output : 1'b1;  // [RULE_19] [RULE_21]
            SERIAL_CLK      <= run_bit_t1 & serial_div;                     // [RULE_22]
            IRQ_T0          <= underflow_flag_t0 & underflow_mask_t0;       // [RULE_16]
            IRQ_T1          <= underflow_flag_t1 & underflow_mask_t1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_load0;
        WR && ADDR == REG_T0CTL && WDATA[TC_LOAD_BIT];
    endsequence
    sequence s_read0_lo;
        RD && ADDR == REG_CNT0_LO;
    endsequence

    a_load_copies: assert property (s_load0 |=> ch_count[0] == $past(reload_value_t0))  // [RULE_02]
        else $error("reload strobe did not load counter");
    a_stop_holds: assert property (!run_bit_t0 && !reload_strobe_t0 |=> $stable(ch_count[0]))  // [RULE_03]
        else $error("stopped counter changed");
    a_uf_reload: assert property (uf[0] |-> ch_count[0] == $past(reload_value_t0))  // [RULE_25]
        else $error("underflow did not reload");
    a_flag_set: assert property (uf[1] |=> underflow_flag_t1)  // [RULE_16]
        else $error("underflow flag not set");
    a_toggle_flip: assert property (sel_uf |=> toggle_output != $past(toggle_output))  // [RULE_17]
        else $error("toggle did not flip");
    a_pin_high: assert property (!toggle_output_enable |=> TOGGLE_PORT_PIN)  // [RULE_19]
        else $error("disabled pin not high");
    a_hold_nibble: assert property (s_read0_lo |=> hold0 == $past(ch_count[0][7:4]))  // [RULE_04]
        else $error("high nibble not latched");
    a_nr_accept: assert property (noise_reject_enable && $past(noise_reject_enable) && $changed(ev_accept)
                                  |-> $past(nr_fall) && $past(flt_state) == FLT_HALF)  // [RULE_10]
        else $error("event accepted off second reference fall");
    a_serial_gate: assert property (!run_bit_t1 |=> !SERIAL_CLK)  // [RULE_22]
        else $error("serial clock while timer 1 stopped");
endmodule

// >>> logic/drt_pkg.sv
/*
 * Shared constants for the dual reload down timer: register offsets,
 * field positions, prescaler codes and reset values.
 * Assumes a 4-bit register port and a 32.768 kHz low-speed oscillator.
 */
package drt_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 4;
    localparam int CNT_W  = 8;

    // register offsets
    localparam logic [3:0] REG_EVCTL   = 4'h0;
    localparam logic [3:0] REG_OUTCTL  = 4'h1;
    localparam logic [3:0] REG_T0CTL   = 4'h2;
    localparam logic [3:0] REG_T1CTL   = 4'h3;
    localparam logic [3:0] REG_RLD0_LO = 4'h4;
    localparam logic [3:0] REG_RLD0_HI = 4'h5;
    localparam logic [3:0] REG_RLD1_LO = 4'h6;
    localparam logic [3:0] REG_RLD1_HI = 4'h7;
    localparam logic [3:0] REG_CNT0_LO = 4'h8;
    localparam logic [3:0] REG_CNT0_HI = 4'h9;
    localparam logic [3:0] REG_CNT1_LO = 4'hA;
    localparam logic [3:0] REG_CNT1_HI = 4'hB;
    localparam logic [3:0] REG_FLAG    = 4'hC;
    localparam logic [3:0] REG_MASK    = 4'hD;

    // field positions
    localparam int EV_POL_BIT    = 0;
    localparam int EV_NR_BIT     = 1;
    localparam int EV_MODE_BIT   = 2;
    localparam int OUT_SRC0_BIT  = 0;
    localparam int OUT_SRC1_BIT  = 1;
    localparam int OUT_EN_BIT    = 2;
    localparam int OUT_TOGGLE_CHANNEL_SELECT_BIT = 3;
    localparam int TC_RUN_BIT    = 0;
    localparam int TC_LOAD_BIT   = 1;
    localparam int TC_PS_LSB     = 2;
    localparam int TC_PS_MSB     = 3;

    // prescaler ratio codes and the matching divider masks
    localparam logic [1:0] PS_DIV1   = 2'h0;
    localparam logic [1:0] PS_DIV4   = 2'h1;
    localparam logic [1:0] PS_DIV32  = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [7:0] PS_MASK1   = 8'h00;
    localparam logic [7:0] PS_MASK4   = 8'h03;
    localparam logic [7:0] PS_MASK32  = 8'h1F;
    localparam logic [7:0] PS_MASK256 = 8'hFF;

    // 2,048 Hz reference from the low-speed oscillator (divide by 16)
    localparam int         NR_DIV_W   = 4;
    localparam logic [3:0] NR_DIV_TOP = 4'hF;
    localparam logic [3:0] NR_ONE     = 4'h1;

    // reset values
    localparam logic [7:0] CNT_ZERO  = 8'h00;
    localparam logic [7:0] CNT_ONE   = 8'h01;
    localparam logic [3:0] DATA_ZERO = 4'h0;
    localparam logic [3:0] NR_ZERO   = 4'h0;

    typedef enum {FLT_WAIT, FLT_HALF} drt_flt_e;
endpackage

// >>> logic/drt_channel.sv
/*
 * One timer channel: gated prescaler and 8-bit reloadable down counter.
 * Assumes src_tick and ext_tick are one-cycle pulses on clk.
 */
`timescale 1ns/1ps
module drt_channel
    import drt_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         src_tick,
    input  wire logic         ext_tick,
    input  wire logic         use_ext,
    input  wire logic         run,
    input  wire logic [1:0]   ratio,
    input  wire logic         load,
    input  wire logic [W-1:0] reload,
    output logic      [W-1:0] count,
    output logic              underflow
);
    import drt_pkg::*;

    logic [7:0]   pre;
    logic [7:0]   next_pre;
    logic [7:0]   mask;
    logic [W-1:0] next_count;
    logic         next_underflow;
    logic         pre_tick;
    logic         count_tick;

    // prescaler and counter next values
    always_comb begin
        case (ratio)
            PS_DIV4:   mask = PS_MASK4;
            PS_DIV32:  mask = PS_MASK32;
            PS_DIV256: mask = PS_MASK256;
            default:   mask = PS_MASK1;
        endcase
        next_pre = pre;
        pre_tick = 1'b0;
        if (run && !use_ext && src_tick) begin            // [RULE_14] [RULE_08]
            next_pre = pre + CNT_ONE;
            pre_tick = ((pre & mask) == mask);            // [RULE_13]
        end
        count_tick = run && (use_ext ? ext_tick : pre_tick);  // [RULE_03] [RULE_07]
        next_count = count;
        next_underflow = 1'b0;
        if (load) begin
            next_count = reload;                          // [RULE_02]
        end else if (count_tick) begin
            if (count == W'(CNT_ZERO)) begin
                next_count = reload;                      // [RULE_25] [RULE_05]
                next_underflow = 1'b1;
            end else begin
                next_count = count - W'(CNT_ONE);         // [RULE_01]
            end
        end
    end

    // register the channel state
    always_ff @(posedge clk) begin
        if (rst) begin
            pre       <= CNT_ZERO;
            count     <= W'(CNT_ZERO);
            underflow <= 1'b0;
        end else begin
            pre       <= next_pre;
            count     <= next_count;
            underflow <= next_underflow;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pre_hold: assert property (!run |=> pre == $past(pre))  // [RULE_14]
        else $error("prescaler moved while stopped");
endmodule

// >>> tb/drt_partner.sv
/* Far side model: oscillator pins, event pin, serial clock watcher.
   Assumes the bench sets ev and reads the edge counts. */
`timescale 1ns/1ps
module drt_partner (
    input  wire logic ev,
    input  wire logic ser_clk,
    input  wire logic pin,
    output logic      osc_lo,
    output logic      osc_hi,
    output logic      ev_pin,
    output int        ser_n,
    output int        pin_n
);
    // free running sources, high one on long before any use
    initial osc_lo = 1'b0;
    initial osc_hi = 1'b0;
    always #500 osc_lo = ~osc_lo;
    always #310 osc_hi = ~osc_hi;
    // event level held as long as the bench asks
    assign ev_pin = ev;
    // serial side counts clock rises, about 0.8 MHz at most
    initial ser_n = 0;
    initial pin_n = 0;
    always @(posedge ser_clk) ser_n++;
    always @(posedge pin) pin_n++;
endmodule

// >>> tb/dual_reload_down_timer_bench.sv
/* Directed bench for the dual reload down timer over its register port.
   Assumes the partner model drives the oscillator and event pins. */
`timescale 1ns/1ps
module dual_reload_down_timer_bench;
    import drt_pkg::*;
    logic       mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ev = 1'b0;
    logic [3:0] addr = 4'h0, wdata = 4'h0, rdata;
    logic       lo, hi, evp, pin, ser, irq0, irq1;
    logic [7:0] v, w;
    int         ser_n, pin_n, s0, miscompares = 0, compares = 0;
    int         dvt[4] = '{1, 4, 32, 256};
    // bus clock
    always #50 mclk = ~mclk;
    drt_timer DUT (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .LOW_SPEED_OSCILLATOR(lo), .HIGH_SPEED_OSCILLATOR(hi), .EVENT_INPUT_PIN(evp),
        .TOGGLE_PORT_PIN(pin), .SERIAL_CLK(ser), .IRQ_T0(irq0), .IRQ_T1(irq1));
    drt_partner P (.ev(ev), .ser_clk(ser), .pin(pin), .osc_lo(lo), .osc_hi(hi), .ev_pin(evp),
        .ser_n(ser_n), .pin_n(pin_n));
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [3:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a, output logic [3:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // low nibble first, then the held high nibble
    task automatic rdc(input logic [3:0] a, output logic [7:0] c);
        rdr(a, c[3:0]);
        rdr(a + 4'h1, c[7:4]);
    endtask
    task automatic evs(input logic b, input int n);
        @(posedge mclk);
        ev <= b;
        cyc(n);
    endtask
    task automatic report_and_stop;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        cyc(40000);
        miscompares++;
        report_and_stop;
    end
    // main sequence
    initial begin
        cyc(2);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rdr(a[3:0], v[3:0]);
            chk({4'h0, v[3:0]}, 8'h00);
        end
        chk({7'h0, pin}, 8'h01);
        wrr(REG_RLD0_LO, 4'h5);
        wrr(REG_RLD0_HI, 4'h3);
        wrr(REG_T0CTL, 4'h0);
        rdc(REG_CNT0_LO, v);
        chk(v, 8'h00);
        wrr(REG_T0CTL, 4'h2);
        rdc(REG_CNT0_LO, v);
        chk(v, 8'h35);
        // a new load between the two halves must not reach the held nibble
        rdr(REG_CNT0_LO, v[3:0]);
        wrr(REG_RLD0_HI, 4'h0);
        wrr(REG_RLD0_LO, 4'h2);
        wrr(REG_T0CTL, 4'h2);
        rdr(REG_CNT0_HI, v[7:4]);
        chk(v, 8'h35);
        // event counting with prescaler fields set, toggle shown on the pin
        wrr(REG_EVCTL, 4'h4);
        wrr(REG_OUTCTL, 4'h5);
        wrr(REG_T0CTL, 4'hD);
        evs(1'b1, 20);
        chk({7'h0, pin}, 8'h00);
        rdc(REG_CNT0_LO, v);
        chk(v, 8'h02);
        for (int i = 1; i >= 0; i--) begin
            evs(1'b0, 20);
            evs(1'b1, 20);
            rdc(REG_CNT0_LO, v);
            chk(v, i[7:0]);
        end
        evs(1'b0, 20);
        rdc(REG_CNT0_LO, v);
        chk(v, 8'h02);
        chk({7'h0, pin}, 8'h01);
        rdr(REG_FLAG, v[3:0]);
        chk({4'h0, v[3:0]}, 8'h01);
        chk({7'h0, irq0}, 8'h00);
        wrr(REG_MASK, 4'h1);
        cyc(2);
        chk({7'h0, irq0}, 8'h01);
        wrr(REG_FLAG, 4'h1);
        cyc(2);
        chk({7'h0, irq0}, 8'h00);
        // rising edges, then a halt that keeps the value
        wrr(REG_EVCTL, 4'h5);
        evs(1'b1, 20);
        wrr(REG_T0CTL, 4'hC);
        evs(1'b0, 20);
        evs(1'b1, 20);
        rdc(REG_CNT0_LO, v);
        chk(v, 8'h01);
        // noise rejector: short glitch dropped, long level taken
        wrr(REG_EVCTL, 4'h6);
        wrr(REG_T0CTL, 4'hD);
        evs(1'b0, 30);
        evs(1'b1, 400);
        rdc(REG_CNT0_LO, v);
        chk(v, 8'h01);
        evs(1'b0, 400);
        rdc(REG_CNT0_LO, v);
        chk(v, 8'h00);
        // prescaler ratios on the low-speed source, about five ticks each
        wrr(REG_EVCTL, 4'h0);
        wrr(REG_OUTCTL, 4'h0);
        wrr(REG_RLD0_LO, 4'hF);
        wrr(REG_RLD0_HI, 4'hF);
        for (int r = 0; r < 4; r++) begin
            wrr(REG_T0CTL, {r[1:0], 2'b10});
            wrr(REG_T0CTL, {r[1:0], 2'b01});
            cyc(50 * dvt[r]);
            wrr(REG_T0CTL, {r[1:0], 2'b00});
            rdc(REG_CNT0_LO, v);
            chk((8'hFF - v >= 8'h04 && 8'hFF - v <= 8'h06) ? 8'h01 : 8'h00, 8'h01);
        end
        cyc(300);
        rdc(REG_CNT0_LO, w);
        chk(w, v);
        // timer 1 on the high-speed source, reload zero, as serial clock
        wrr(REG_EVCTL, 4'h4);
        wrr(REG_OUTCTL, 4'hA);
        wrr(REG_T1CTL, 4'h3);
        s0 = ser_n;
        cyc(248);
        chk((ser_n - s0 >= 18 && ser_n - s0 <= 22) ? 8'h01 : 8'h00, 8'h01);
        chk({7'h0, pin}, 8'h01);
        wrr(REG_OUTCTL, 4'hE);
        s0 = pin_n;
        cyc(248);
        chk((pin_n - s0 >= 18 && pin_n - s0 <= 22) ? 8'h01 : 8'h00, 8'h01);
        // timer 1 underflows keep its flag set; only its mask is open now
        wrr(REG_MASK, 4'h2);
        cyc(2);
        chk({6'h0, irq1, irq0}, 8'h02);
        rdr(REG_FLAG, v[3:0]);
        chk({4'h0, v[3:0]}, 8'h02);
        wrr(REG_T1CTL, 4'h0);
        cyc(20);
        chk({7'h0, ser}, 8'h00);
        report_and_stop;
    end
endmodule
